/* File: hw/sms_pkg.sv */
// package: command encodings, parameter addresses, field positions, timing
package sms_pkg;
  localparam int CMD_W = 8;
  localparam int PADDR_W = 5;
  localparam int PARAM_DEPTH = 32;
  localparam int RESULT_W = 16;
  localparam int NCHAN = 6;
  // opcode field of a command byte
  localparam int OP_HI = 7;
  localparam int OP_LO = 5;
  localparam logic [2:0] OP_MISC = 3'h0;
  localparam logic [2:0] OP_QUERY = 3'h4;
  localparam logic [2:0] OP_SET = 3'h5;
  localparam logic [2:0] OP_AND = 3'h6;
  localparam logic [2:0] OP_OR = 3'h7;
  // misc command codes
  localparam logic [7:0] CMD_NULL_OP = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h01;
  localparam logic [7:0] CMD_SINGLE_PROX = 8'h05;
  localparam logic [7:0] CMD_SINGLE_AMB = 8'h06;
  localparam logic [7:0] CMD_SINGLE_BOTH = 8'h07;
  localparam logic [7:0] CMD_PAUSE_PROX = 8'h09;
  localparam logic [7:0] CMD_PAUSE_AMB = 8'h0a;
  localparam logic [7:0] CMD_PAUSE_BOTH = 8'h0b;
  localparam logic [7:0] CMD_LOOP_PROX = 8'h0d;
  localparam logic [7:0] CMD_LOOP_AMB = 8'h0e;
  localparam logic [7:0] CMD_LOOP_BOTH = 8'h0f;
  // parameter ram addresses
  localparam logic [4:0] PAR_CHANNEL_ENABLE_LIST = 5'h01;
  localparam logic [4:0] PAR_PROX_DIV = 5'h02;
  localparam logic [4:0] PAR_AMB_DIV = 5'h03;
  // channel enable bits: prox 0..2, visible, infrared, auxiliary
  localparam int CH_PROX_LO = 0;
  localparam int CH_AMB_LO = 3;
  // response register
  localparam logic [3:0] RSP_ERR_INVALID = 4'h8;
  localparam logic [7:0] RSP_ZERO = 8'h00;
  // result order in the flat result bus: ambient first, then prox
  localparam int RES_AMB_BASE = 0;
  localparam int RES_PROX_BASE = 3;
  // reset holdoff after a reset command, in microseconds
  localparam int RESET_HOLD_US = 1000;
  localparam int CLK_MHZ = 125;
endpackage

/* File: hw/sms_conv.sv */
// one measurement conversion: fixed latency, result handed in by the front end
`timescale 1ns/1ns
module sms_conv #(
  parameter int LAT = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // request and completion
  input wire logic start_i,
  input wire logic [sms_pkg::RESULT_W-1:0] sample_i,
  output logic done_o,
  output logic [sms_pkg::RESULT_W-1:0] data_o
);
  logic [7:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic [sms_pkg::RESULT_W-1:0] data_ff, nxt_data;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_data = data_ff;
    if (start_i && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_cnt = 8'(LAT);
    end else if (busy_ff) begin
      if (cnt_ff == 8'h01) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_data = sample_i;
      end
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      data_ff <= nxt_data;
    end
  end

  assign done_o = done_ff;
  assign data_o = data_ff;
endmodule // sms_conv

/* File: hw/sms_seq.sv */
// measurement sequencer: command interpreter, autonomous loop, results
`timescale 1ns/1ns
// What this block does and what its host must do
// [R1] base wake interval zero: sleep, measure only on command writes
// [R2] non-zero base wake interval: wake periodically at that interval while a prox or ambient loop runs
// [R3] each wake advances prox and ambient counters, reloaded from dividers
// [R4] prox group runs enabled channels one, two, three in order
// [R5] ambient group runs visible, infrared, auxiliary in order
// [R6] divider zero disables group; divider one runs every wake
// [R7] both due on one wake: prox group before ambient group
// [R8] after all due measurements, sequencer sleeps until next wake
// [R9] other register accesses never wake the sequencer
// [R10] each result stored in its own 16-bit readable register
// [R11] host sets rates before loop start, multiples of base rate
// [R12] polling host samples results at twice the conversion rate
// [R13] enabled threshold crossing raises interrupt to host
// [R14] status first, then ambient results, then prox results
// [R15] error-free completion: upper nibble zero, lower counter increments
// [R16] non-zero upper nibble reports error or special handling
// [R17] command 0x00 clears response; host polls until non-zero
// [R18] host repeats sequence if response stays zero past 25 ms
// [R19] reset command resets without count; host waits 1 ms
// [R20] 100 aaaaa copies parameter entry to read mailbox
// [R21] 101 aaaaa stores write mailbox into entry, echoes to read mailbox
// [R22] 110 aaaaa ANDs write mailbox into entry, echoes result
// [R23] 111 aaaaa ORs write mailbox into entry, echoes result
// [R24] 000 00000 forces response to zero, clearing the counter
// [R25] 05, 06, 07 trigger single prox, ambient, both measurements
// [R26] 0d, 0e, 0f start or restart prox, ambient, both loops
// [R27] completion counter wraps fifteen to zero, upper nibble zero
module sms_seq #(
  parameter int TICK_CYC = 1250,
  parameter int CONV_LAT = 4,
  parameter int HOLD_CYC = sms_pkg::RESET_HOLD_US * sms_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // host register writes
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [7:0] parameter_write_mailbox_mbox_i,
  input wire logic [7:0] base_wake_interval_i,
  // threshold configuration
  input wire logic irq_prox_en_i,
  input wire logic irq_amb_en_i,
  input wire logic [15:0] prox_thresh_i,
  input wire logic [15:0] amb_thresh_i,
  // analog front end sample
  input wire logic [15:0] sample_i,
  input wire logic sample_ovf_i,
  // host readable state
  output logic [7:0] response_o,
  output logic [7:0] parameter_read_mailbox_mbox_o,
  output logic [7:0] irq_status_o,
  output logic [6*16-1:0] results_o,
  output logic irq_o,
  output logic awake_o,
  output logic [2:0] conv_chan_o,
  output logic conv_start_o
);
  typedef enum logic [2:0] {
    SMS_SLEEP, SMS_EXEC, SMS_MEAS, SMS_WAIT, SMS_HOLD
  } sms_state_t;
  function automatic logic [2:0] sms_next_chan(input logic [5:0] pend);
    logic [2:0] c;
    c = 3'h0;
    for (int i = sms_pkg::NCHAN - 1; i >= 0; i--) begin
      if (pend[i]) c = 3'(i);
    end
    return c;
  endfunction
  sms_state_t st_ff, nxt_st;
  logic [7:0] par_ff [sms_pkg::PARAM_DEPTH], nxt_par [sms_pkg::PARAM_DEPTH];
  logic [15:0] res_ff [sms_pkg::NCHAN], nxt_res [sms_pkg::NCHAN];
  logic [7:0] rsp_ff, nxt_rsp, rdmb_ff, nxt_rdmb, cmd_ff, nxt_cmd;
  logic [7:0] irqs_ff, nxt_irqs, wake_ff, nxt_wake;
  logic prox_loop_ff, nxt_prox_loop, amb_loop_ff, nxt_amb_loop;
  logic [7:0] pcnt_ff, nxt_pcnt, acnt_ff, nxt_acnt;
  logic [31:0] tick_ff, nxt_tick, hold_ff, nxt_hold;
  logic [5:0] pend_ff, nxt_pend, chl;
  logic [2:0] chan_ff, nxt_chan;
  logic [15:0] conv_data;
  logic cmd_pend_ff, nxt_cmd_pend, start_ff, nxt_start;
  logic irq_ff, nxt_irq, awake_ff, nxt_awake;
  logic count_done_ff, nxt_count_done, conv_done, wake_due;
  sms_conv #(.LAT(CONV_LAT)) u_conv (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start_ff),
    .sample_i(sample_i),
    .done_o(conv_done),
    .data_o(conv_data)
  );
  assign chl = par_ff[sms_pkg::PAR_CHANNEL_ENABLE_LIST][5:0];
  // base wake timer; tick counts cycles, wake counts ticks
  always_comb begin
    nxt_tick = tick_ff;
    nxt_wake = wake_ff;
    wake_due = 1'b0;
    if (base_wake_interval_i == 8'h00) begin // [R1]
      nxt_tick = '0;
      nxt_wake = '0;
    end else if (tick_ff >= 32'(TICK_CYC - 1)) begin
      nxt_tick = '0;
      if (wake_ff >= base_wake_interval_i - 8'h01) begin // [R2]
        nxt_wake = 8'h00;
        wake_due = prox_loop_ff || amb_loop_ff;
      end else begin
        nxt_wake = wake_ff + 8'h01;
      end
    end else begin
      nxt_tick = tick_ff + 32'h1;
    end
  end
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < sms_pkg::PARAM_DEPTH; i++) nxt_par[i] = par_ff[i];
    for (int i = 0; i < sms_pkg::NCHAN; i++) nxt_res[i] = res_ff[i];
    nxt_rsp = rsp_ff;
    nxt_rdmb = rdmb_ff;
    nxt_cmd = cmd_ff;
    nxt_cmd_pend = cmd_pend_ff;
    nxt_irqs = irqs_ff;
    nxt_prox_loop = prox_loop_ff;
    nxt_amb_loop = amb_loop_ff;
    nxt_pcnt = pcnt_ff;
    nxt_acnt = acnt_ff;
    nxt_pend = pend_ff;
    nxt_chan = chan_ff;
    nxt_start = 1'b0;
    nxt_hold = hold_ff;
    nxt_count_done = count_done_ff;
    // of the host writes, only a command write wakes the sequencer [R9]
    if (cmd_wr_i) begin
      nxt_cmd = cmd_data_i;
      nxt_cmd_pend = 1'b1;
    end
    case (st_ff)
      SMS_SLEEP: begin
        if (cmd_pend_ff) begin
          nxt_cmd_pend = cmd_wr_i;
          nxt_st = SMS_EXEC;
        end else if (wake_due) begin
          // advance group counters; divider zero never fires [R3] [R6]
          nxt_pend = '0;
          if (prox_loop_ff && par_ff[sms_pkg::PAR_PROX_DIV] != 8'h00) begin
            if (pcnt_ff <= 8'h01) begin
              nxt_pcnt = par_ff[sms_pkg::PAR_PROX_DIV];
              nxt_pend[2:0] = chl[2:0]; // [R4]
            end else begin
              nxt_pcnt = pcnt_ff - 8'h01;
            end
          end
          if (amb_loop_ff && par_ff[sms_pkg::PAR_AMB_DIV] != 8'h00) begin
            if (acnt_ff <= 8'h01) begin
              nxt_acnt = par_ff[sms_pkg::PAR_AMB_DIV];
              nxt_pend[5:3] = chl[5:3]; // [R5]
            end else begin
              nxt_acnt = acnt_ff - 8'h01;
            end
          end
          nxt_count_done = 1'b0;
          nxt_st = SMS_MEAS;
        end
      end
      SMS_EXEC: begin
        nxt_st = SMS_SLEEP;
        nxt_count_done = 1'b1;
        case (cmd_ff[sms_pkg::OP_HI:sms_pkg::OP_LO])
          sms_pkg::OP_QUERY: nxt_rdmb = par_ff[cmd_ff[4:0]]; // [R20]
          sms_pkg::OP_SET: begin
            nxt_par[cmd_ff[4:0]] = parameter_write_mailbox_mbox_i; // [R21]
            nxt_rdmb = parameter_write_mailbox_mbox_i;
          end
          sms_pkg::OP_AND: begin
            nxt_par[cmd_ff[4:0]] = par_ff[cmd_ff[4:0]] & parameter_write_mailbox_mbox_i;
            nxt_rdmb = par_ff[cmd_ff[4:0]] & parameter_write_mailbox_mbox_i; // [R22]
          end
          sms_pkg::OP_OR: begin
            nxt_par[cmd_ff[4:0]] = par_ff[cmd_ff[4:0]] | parameter_write_mailbox_mbox_i;
            nxt_rdmb = par_ff[cmd_ff[4:0]] | parameter_write_mailbox_mbox_i; // [R23]
          end
          default: begin
            nxt_count_done = 1'b0;
            case (cmd_ff)
              sms_pkg::CMD_NULL_OP: nxt_rsp = sms_pkg::RSP_ZERO; // [R17] [R24]
              sms_pkg::CMD_RESET: begin
                // wipe state, no count, then refuse commands for 1 ms [R19]
                for (int i = 0; i < sms_pkg::PARAM_DEPTH; i++)
                  nxt_par[i] = 8'h00;
                nxt_rsp = sms_pkg::RSP_ZERO;
                nxt_rdmb = 8'h00;
                nxt_prox_loop = 1'b0;
                nxt_amb_loop = 1'b0;
                nxt_hold = 32'(HOLD_CYC);
                nxt_st = SMS_HOLD;
              end
              sms_pkg::CMD_SINGLE_PROX, sms_pkg::CMD_SINGLE_AMB,
              sms_pkg::CMD_SINGLE_BOTH: begin // [R25]
                nxt_pend = '0;
                if (cmd_ff[0]) nxt_pend[2:0] = chl[2:0];
                if (cmd_ff[1]) nxt_pend[5:3] = chl[5:3];
                nxt_count_done = 1'b1;
                nxt_st = SMS_MEAS;
              end
              sms_pkg::CMD_LOOP_PROX, sms_pkg::CMD_LOOP_AMB,
              sms_pkg::CMD_LOOP_BOTH: begin // [R26]
                if (cmd_ff[0]) begin
                  nxt_prox_loop = 1'b1;
                  nxt_pcnt = 8'h01;
                end
                if (cmd_ff[1]) begin
                  nxt_amb_loop = 1'b1;
                  nxt_acnt = 8'h01;
                end
                nxt_count_done = 1'b1;
              end
              sms_pkg::CMD_PAUSE_PROX, sms_pkg::CMD_PAUSE_AMB,
              sms_pkg::CMD_PAUSE_BOTH: begin
                if (cmd_ff[0]) nxt_prox_loop = 1'b0;
                if (cmd_ff[1]) nxt_amb_loop = 1'b0;
                nxt_count_done = 1'b1;
              end
              default: nxt_rsp = {sms_pkg::RSP_ERR_INVALID, 4'h0}; // [R16]
            endcase
          end
        endcase
      end
      SMS_MEAS: begin
        // lowest pending index first: prox before ambient [R7]
        if (pend_ff == 6'h00) begin
          nxt_st = SMS_SLEEP; // [R8]
        end else begin
          nxt_chan = sms_next_chan(pend_ff);
          nxt_pend[sms_next_chan(pend_ff)] = 1'b0;
          nxt_start = 1'b1;
          nxt_st = SMS_WAIT;
        end
      end
      SMS_WAIT: begin
        if (conv_done) begin
          nxt_res[chan_ff] = conv_data; // [R10]
          if (sample_ovf_i) begin
            nxt_rsp = {sms_pkg::RSP_ERR_INVALID, 1'b1, chan_ff}; // [R16]
            nxt_count_done = 1'b0;
          end
          if (chan_ff < 3'(sms_pkg::CH_AMB_LO)) begin
            if (irq_prox_en_i && conv_data >= prox_thresh_i)
              nxt_irqs[0] = 1'b1; // [R13]
          end else if (irq_amb_en_i && conv_data >= amb_thresh_i) begin
            nxt_irqs[1] = 1'b1; // [R13]
          end
          nxt_st = SMS_MEAS;
        end
      end
      SMS_HOLD: begin
        nxt_cmd_pend = 1'b0;
        if (hold_ff == 32'h0) nxt_st = SMS_SLEEP;
        else nxt_hold = hold_ff - 32'h1;
      end
      default: nxt_st = SMS_SLEEP;
    endcase
    // count only once asleep again and with no error latched [R15] [R27]
    if (count_done_ff && st_ff == SMS_SLEEP && rsp_ff[7:4] == 4'h0) begin
      nxt_rsp = {4'h0, rsp_ff[3:0] + 4'h1};
      nxt_count_done = 1'b0;
    end
    // status flags clear only on a null command
    if (st_ff == SMS_EXEC && cmd_ff == sms_pkg::CMD_NULL_OP) nxt_irqs = '0;
  end
  assign nxt_irq = |irqs_ff;
  assign nxt_awake = (nxt_st != SMS_SLEEP);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= SMS_SLEEP;
      for (int i = 0; i < sms_pkg::PARAM_DEPTH; i++) par_ff[i] <= 8'h00;
      for (int i = 0; i < sms_pkg::NCHAN; i++) res_ff[i] <= 16'h0000;
      rsp_ff <= 8'h00;
      rdmb_ff <= 8'h00;
      cmd_ff <= 8'h00;
      cmd_pend_ff <= 1'b0;
      irqs_ff <= 8'h00;
      irq_ff <= 1'b0;
      prox_loop_ff <= 1'b0;
      amb_loop_ff <= 1'b0;
      pcnt_ff <= 8'h00;
      acnt_ff <= 8'h00;
      tick_ff <= 32'h0;
      wake_ff <= 8'h00;
      pend_ff <= 6'h00;
      chan_ff <= 3'h0;
      start_ff <= 1'b0;
      hold_ff <= 32'h0;
      count_done_ff <= 1'b0;
      awake_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      par_ff <= nxt_par;
      res_ff <= nxt_res;
      rsp_ff <= nxt_rsp;
      rdmb_ff <= nxt_rdmb;
      cmd_ff <= nxt_cmd;
      cmd_pend_ff <= nxt_cmd_pend;
      irqs_ff <= nxt_irqs;
      irq_ff <= nxt_irq;
      prox_loop_ff <= nxt_prox_loop;
      amb_loop_ff <= nxt_amb_loop;
      pcnt_ff <= nxt_pcnt;
      acnt_ff <= nxt_acnt;
      tick_ff <= nxt_tick;
      wake_ff <= nxt_wake;
      pend_ff <= nxt_pend;
      chan_ff <= nxt_chan;
      start_ff <= nxt_start;
      hold_ff <= nxt_hold;
      count_done_ff <= nxt_count_done;
      awake_ff <= nxt_awake;
    end
  end

  // flat result bus: ambient words first, then prox words [R14]
  always_comb begin
    results_o = '0;
    for (int i = 0; i < 3; i++) begin
      results_o[(sms_pkg::RES_AMB_BASE + i) * 16 +: 16] = res_ff[3 + i];
      results_o[(sms_pkg::RES_PROX_BASE + i) * 16 +: 16] = res_ff[i];
    end
  end

  assign response_o = rsp_ff;
  assign parameter_read_mailbox_mbox_o = rdmb_ff;
  assign irq_status_o = irqs_ff;
  assign irq_o = irq_ff;
  assign awake_o = awake_ff;
  assign conv_chan_o = chan_ff;
  assign conv_start_o = start_ff;
endmodule // sms_seq

/* File: tb/sms_seq_asserts.sv */
// port-level checks on the measurement sequencer
`timescale 1ns/1ns
module sms_seq_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // host side
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [7:0] parameter_write_mailbox_mbox_i,
  input wire logic [7:0] base_wake_interval_i,
  input wire logic sample_ovf_i,
  // readable state
  input wire logic [7:0] response_o,
  input wire logic [7:0] parameter_read_mailbox_mbox_o,
  input wire logic [7:0] irq_status_o,
  input wire logic [6*16-1:0] results_o,
  input wire logic irq_o,
  input wire logic awake_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic conv_start_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // lowest channel still allowed in this wake; each conversion start raises it past that channel
  logic [3:0] floor_ff;
  logic [3:0] nxt_floor;
  always_comb begin
    nxt_floor = floor_ff;
    if (!awake_o) nxt_floor = 4'h0;
    else if (conv_start_o) nxt_floor = {1'b0, conv_chan_o} + 4'h1;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) floor_ff <= 4'h0;
    else floor_ff <= nxt_floor;
  end
  chk_sleep_no_cmd: assert property (
    (base_wake_interval_i == 8'h00 && !cmd_wr_i) [*6] |-> !$rose(awake_o))
    else $error("sequencer woke with no command write");
  chk_rsp_count: assert property (
    $changed(response_o) && response_o[7:4] == 4'h0 && response_o != 8'h00
    |-> response_o[3:0] == $past(response_o[3:0]) + 4'h1)
    else $error("completion count did not step by one");
  chk_null_clears: assert property (
    cmd_wr_i && cmd_data_i == sms_pkg::CMD_NULL_OP && !awake_o &&
    base_wake_interval_i == 8'h00 |-> ##[1:3] response_o == 8'h00)
    else $error("null command left response non-zero");
  chk_set_echo: assert property (
    cmd_wr_i && cmd_data_i[7:5] == sms_pkg::OP_SET && !awake_o &&
    base_wake_interval_i == 8'h00
    |-> ##[1:4] parameter_read_mailbox_mbox_o == parameter_write_mailbox_mbox_i)
    else $error("write command did not echo the mailbox");
  chk_chan_order: assert property (
    conv_start_o |-> {1'b0, conv_chan_o} >= floor_ff && conv_chan_o <= 3'h5)
    else $error("conversion channel out of order");
  chk_back_to_sleep: assert property (
    conv_start_o |-> ##[1:48] !awake_o)
    else $error("sequencer stayed awake after its measurements");
  chk_irq_follows: assert property (
    irq_status_o != 8'h00 |-> ##[0:1] irq_o)
    else $error("status flag set without interrupt line");
  chk_result_upd: assert property (
    conv_start_o && !sample_ovf_i |-> ##[1:8] $changed(results_o))
    else $error("conversion left the results unchanged");
endmodule // sms_seq_chk
bind sms_seq sms_seq_chk i_sms_seq_chk (.sys_clk_i, .rst_b_i, .cmd_wr_i,
  .cmd_data_i, .parameter_write_mailbox_mbox_i, .base_wake_interval_i, .sample_ovf_i,
  .response_o, .parameter_read_mailbox_mbox_o, .irq_status_o, .results_o, .irq_o,
  .awake_o, .conv_chan_o, .conv_start_o);

/* File: tb/sms_afe_model.sv */
// front end stand-in: one numbered sample per conversion request
`timescale 1ns/1ns
module sms_afe_model #(
  parameter int HOLD = 6
) (
  // clock
  input wire logic sys_clk_i,
  // conversion request
  input wire logic conv_start_i,
  input wire logic [2:0] conv_chan_i,
  input wire logic ovf_req_i,
  // sample out
  output logic [15:0] sample_o,
  output logic sample_ovf_o
);
  logic [11:0] seq_ff = 12'h000;
  logic [15:0] val_ff = 16'h0000;
  int age = 0;
  // past the hold the value churns, so a late capture cannot pass
  always @(posedge sys_clk_i) begin
    if (conv_start_i) begin
      seq_ff <= seq_ff + 12'h001;
      val_ff <= {1'b0, conv_chan_i, seq_ff + 12'h001};
      age <= 0;
    end else if (age < HOLD) age <= age + 1;
    else val_ff <= ~val_ff;
  end
  assign sample_o = val_ff;
  assign sample_ovf_o = ovf_req_i;
endmodule // sms_afe_model

/* File: tb/sms_seq_tb.sv */
// self-checking bench for the measurement sequencer
`timescale 1ns/1ns
module sms_seq_tb;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_wr_i = 1'b0;
  logic irq_prox_en_i = 1'b0;
  logic irq_amb_en_i = 1'b0;
  logic ovf_req = 1'b0;
  logic [7:0] cmd_data_i = 8'h00;
  logic [7:0] parameter_write_mailbox_mbox_i = 8'h00;
  logic [7:0] base_wake_interval_i = 8'h00;
  logic [15:0] prox_thresh_i = 16'hffff;
  logic [15:0] amb_thresh_i = 16'hffff;
  logic [15:0] sample_i;
  logic sample_ovf_i, irq_o, awake_o, conv_start_o;
  logic [7:0] response_o, parameter_read_mailbox_mbox_o, irq_status_o;
  logic [95:0] results_o;
  logic [2:0] conv_chan_o;
  logic [11:0] last_seq [8];
  int mismatches = 0;
  int checks_done = 0;
  int n_conv = 0;
  int cyc = 0;
  int log_q[$];
  int t_q[$];
  always #4 sys_clk_i = ~sys_clk_i;
  // short tick and hold keep the run brief; expectations use these values
  sms_seq #(.TICK_CYC(10), .HOLD_CYC(50)) i_sms_seq (.*);
  sms_afe_model i_sms_afe_model (
    .sys_clk_i,
    .conv_start_i(conv_start_o),
    .conv_chan_i(conv_chan_o),
    .ovf_req_i(ovf_req),
    .sample_o(sample_i),
    .sample_ovf_o(sample_ovf_i)
  );
  always @(posedge sys_clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) begin
      n_conv++;
      last_seq[conv_chan_o] = 12'(n_conv);
      log_q.push_back(int'(conv_chan_o));
      t_q.push_back(cyc);
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] c);
    @(negedge sys_clk_i);
    cmd_wr_i = 1'b1;
    cmd_data_i = c;
    @(negedge sys_clk_i);
    cmd_wr_i = 1'b0;
  endtask
  // wait until response equals v (eq) or leaves v (!eq), bounded
  task automatic poll(input logic [7:0] v, input bit eq, input int lim);
    for (int n = 0; n < lim && ((response_o === v) != eq); n++)
      @(negedge sys_clk_i);
  endtask
  // an unanswered command is sent again from the clearing write
  task automatic host_cmd(input logic [7:0] c);
    bit answered;
    answered = 1'b0;
    for (int t = 0; t < 2 && !answered; t++) begin
      send(sms_pkg::CMD_NULL_OP);
      poll(8'h00, 1'b1, 100);
      check("cleared", 16'(response_o), 16'h0000);
      send(c);
      poll(8'h00, 1'b0, 400);
      answered = (response_o !== 8'h00);
    end
  endtask
  task automatic cfg(input logic [4:0] a, input logic [7:0] v);
    parameter_write_mailbox_mbox_i = v;
    host_cmd({sms_pkg::OP_SET, a});
  endtask
  task automatic t_params;
    logic [2:0] op [4] = '{sms_pkg::OP_SET, sms_pkg::OP_QUERY,
      sms_pkg::OP_AND, sms_pkg::OP_OR};
    logic [7:0] mb [4] = '{8'ha5, 8'h00, 8'h0f, 8'h30};
    logic [7:0] ex [4] = '{8'ha5, 8'ha5, 8'h05, 8'h35};
    check("reset rsp", 16'(response_o), 16'h0000);
    foreach (op[i]) begin
      parameter_write_mailbox_mbox_i = mb[i];
      host_cmd({op[i], 5'h1f});
      check("rd mbox", 16'(parameter_read_mailbox_mbox_o), 16'(ex[i]));
      check("rsp", 16'(response_o), 16'h0001);
    end
    $display("parameter commands done");
  endtask
  task automatic t_wrap;
    logic [7:0] prev;
    send(sms_pkg::CMD_NULL_OP);
    poll(8'h00, 1'b1, 100);
    for (int i = 1; i <= 17; i++) begin
      prev = response_o;
      parameter_write_mailbox_mbox_i = 8'(i);
      send({sms_pkg::OP_SET, 5'h04});
      poll(prev, 1'b0, 400);
      check("count", 16'(response_o), 16'(i % 16));
    end
    $display("counter wrap done");
  endtask
  task automatic t_forced;
    logic [7:0] cm [3] = '{sms_pkg::CMD_SINGLE_PROX,
      sms_pkg::CMD_SINGLE_AMB, sms_pkg::CMD_SINGLE_BOTH};
    logic [7:0] chl = 8'h15;
    int j, w, n;
    cfg(sms_pkg::PAR_CHANNEL_ENABLE_LIST, chl);
    foreach (cm[k]) begin
      log_q.delete();
      host_cmd(cm[k]);
      check("meas count", 16'(response_o), 16'h0001);
      repeat (2) @(negedge sys_clk_i);
      j = 0;
      for (int c = 0; c < 6; c++) begin
        if (chl[c] && cm[k][c / 3]) begin
          w = c < 3 ? c + 3 : c - 3;
          check("chan", 16'(log_q[j]), 16'(c));
          check("result", results_o[w*16 +: 16],
            {1'b0, 3'(c), last_seq[c]});
          j++;
        end
      end
      check("convs", 16'(log_q.size()), 16'(j));
    end
    n = n_conv;
    parameter_write_mailbox_mbox_i = 8'h3c;
    repeat (60) @(negedge sys_clk_i);
    check("idle", 16'(n_conv), 16'(n));
    check("asleep", 16'(awake_o), 16'h0000);
    $display("forced measurements done");
  endtask
  task automatic t_auto;
    int e[$];
    int n;
    logic [15:0] prev;
    cfg(sms_pkg::PAR_PROX_DIV, 8'h01);
    cfg(sms_pkg::PAR_AMB_DIV, 8'h02);
    cfg(sms_pkg::PAR_CHANNEL_ENABLE_LIST, 8'h09);
    base_wake_interval_i = 8'h02;
    log_q.delete();
    t_q.delete();
    host_cmd(sms_pkg::CMD_LOOP_BOTH);
    repeat (110) @(negedge sys_clk_i);
    for (int w = 0; w < 4; w++) begin
      e.push_back(0);
      if (w % 2 == 0) e.push_back(3);
    end
    foreach (e[i]) check("loop chan", 16'(log_q[i]), 16'(e[i]));
    check("wake gap", 16'(t_q[2] - t_q[0]), 16'(20));
    cfg(sms_pkg::PAR_AMB_DIV, 8'h00);
    host_cmd(sms_pkg::CMD_LOOP_BOTH);
    log_q.delete();
    // poll the first prox word twice per wake; at least four of the ten polls find a new value
    n = 0;
    prev = results_o[48 +: 16];
    repeat (10) begin
      repeat (10) @(negedge sys_clk_i);
      if (results_o[48 +: 16] !== prev) n++;
      prev = results_o[48 +: 16];
    end
    check("polled", 16'(n >= 4), 16'h0001);
    check("prox runs", 16'(log_q.size() >= 4), 16'h0001);
    foreach (log_q[i]) check("no amb", 16'(log_q[i]), 16'h0000);
    host_cmd(sms_pkg::CMD_PAUSE_BOTH);
    base_wake_interval_i = 8'h00;
    $display("autonomous loop done");
  endtask
  task automatic t_irq;
    irq_prox_en_i = 1'b1;
    irq_amb_en_i = 1'b1;
    prox_thresh_i = 16'h0000;
    amb_thresh_i = 16'h0000;
    host_cmd(sms_pkg::CMD_SINGLE_BOTH);
    repeat (2) @(negedge sys_clk_i);
    check("flags", 16'(irq_status_o), 16'h0003);
    check("irq", 16'(irq_o), 16'h0001);
    send(sms_pkg::CMD_NULL_OP);
    repeat (4) @(negedge sys_clk_i);
    check("flags clr", 16'(irq_status_o), 16'h0000);
    irq_prox_en_i = 1'b0;
    irq_amb_en_i = 1'b0;
    $display("threshold flags done");
  endtask
  task automatic t_errors;
    logic [7:0] rc [5] = '{8'h03, 8'h04, 8'h08, 8'h0c, 8'h1f};
    ovf_req = 1'b1;
    host_cmd(sms_pkg::CMD_SINGLE_PROX);
    check("overflow", 16'(response_o), 16'h0088);
    ovf_req = 1'b0;
    foreach (rc[i]) begin
      host_cmd(rc[i]);
      check("invalid", 16'(response_o), 16'h0080);
    end
    $display("error codes done");
  endtask
  task automatic t_resetcmd;
    send(sms_pkg::CMD_RESET);
    repeat (5) @(negedge sys_clk_i);
    check("reset rsp", 16'(response_o), 16'h0000);
    send({sms_pkg::OP_QUERY, 5'h04});
    repeat (20) @(negedge sys_clk_i);
    check("held off", 16'(response_o), 16'h0000);
    repeat (50) @(negedge sys_clk_i);
    cfg(5'h04, 8'h5a);
    check("after hold", 16'(response_o), 16'h0001);
    $display("reset command done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    t_params();
    t_wrap();
    t_forced();
    t_auto();
    t_irq();
    t_errors();
    t_resetcmd();
    print_verdict();
  end
endmodule // sms_seq_tb
